// >>> logic/frrs_pkg.sv
// Purpose: constants and types for the fault restart retry sequencer
// Assumes: 25 MHz system clock, synchronous active-low reset
// Notes: Behaviour list below
// Behaviour
// - attempts equal retry field bits 5:3
// - code zero: no restart, output stays off
// - code all ones: retry without limit
// - codes one to five give that many attempts
// - attempts exhausted: output off until cleared
// - attempt spacing is delay count times unit
// - delay count code n means 2**n units
// - code six gives exactly six attempts
// - continuous retry stops on off, bias, fault
package frrs_pkg;

    // ------------------------------------------------------------
    // setting field layout
    // ------------------------------------------------------------
    localparam int FRRS_RETRY_MSB = 5;
    localparam int FRRS_RETRY_LSB = 3;
    localparam int FRRS_DELAY_MSB = 2;
    localparam int FRRS_DELAY_LSB = 0;
    localparam logic [2:0] FRRS_RETRY_NONE = 3'h0;
    localparam logic [2:0] FRRS_RETRY_CONT = 3'h7;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int FRRS_CLK_HZ = 25000000;
    localparam int FRRS_UNIT_US_DEFAULT = 1;
    localparam int FRRS_UNIT_CYC_DEFAULT =
        (FRRS_CLK_HZ / 1000000) * FRRS_UNIT_US_DEFAULT;

    // ------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        FRRS_IDLE,
        FRRS_WAIT,
        FRRS_ATTEMPT,
        FRRS_LOCKOUT
    } frrs_state_t;

    // reset value of output enable
    localparam logic FRRS_EN_RESET = 1'b0;

endpackage

// >>> logic/frrs_delay_timer.sv
// Purpose: counts 2**code delay units of programmable cycle length
// Assumes: start is a one-cycle pulse; unit_cycles is at least one
// Notes: done pulses one cycle when the delay has run out
`timescale 1ns/100ps
module frrs_delay_timer
    import frrs_pkg::*;
#(
    parameter int UNIT_W = 24
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [2:0] code,
    input wire logic [UNIT_W-1:0] unit_cycles,
    output logic busy,
    output logic done
);

    logic [UNIT_W-1:0] cyc_reg;
    logic [7:0] units_reg;

    // ------------------------------------------------------------
    // count units then cycles within a unit
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            busy <= 1'b0;
            done <= 1'b0;
            cyc_reg <= '0;
            units_reg <= 8'h00;
        end else begin
            done <= 1'b0;
            if (start) begin
                busy <= 1'b1;
                cyc_reg <= unit_cycles - UNIT_W'(1);
                units_reg <= 8'(8'h01 << code) - 8'h01;
            end else if (busy) begin
                if (cyc_reg != '0) begin
                    cyc_reg <= cyc_reg - UNIT_W'(1);
                end else if (units_reg != 8'h00) begin
                    units_reg <= units_reg - 8'h01;
                    cyc_reg <= unit_cycles - UNIT_W'(1);
                end else begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end

endmodule

// >>> logic/frrs_sequencer.sv
// Purpose: sequences restart attempts after a fault shutdown
// Assumes: fault, clear and command inputs are on the clk domain
// Notes: the delay runs from the fault that ends each attempt
`timescale 1ns/100ps
module frrs_sequencer
    import frrs_pkg::*;
#(
    parameter int UNIT_W = 24,
    parameter logic [UNIT_W-1:0] UNIT_CYCLES =
        UNIT_W'(FRRS_UNIT_CYC_DEFAULT)
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [5:0] fault_setting,
    input wire logic fault_shutdown,
    input wire logic restart_ok,
    input wire logic fault_clear,
    input wire logic cmd_on,
    input wire logic bias_ok,
    input wire logic other_fault,
    output logic output_enable,
    output logic restart_pulse,
    output logic locked_out,
    output logic retrying,
    output logic [2:0] attempts_used
);

    frrs_state_t state_reg;
    logic [2:0] retry_code_reg;
    logic [2:0] delay_code_reg;
    logic [2:0] count_reg;
    logic tmr_start;
    logic tmr_done;
    logic stop_cont;
    logic first_fault;
    logic again_fault;
    logic launch;
    logic [2:0] tmr_code;

    // ------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------
    function automatic logic [2:0] retry_field(input logic [5:0] s);
        return s[FRRS_RETRY_MSB:FRRS_RETRY_LSB];
    endfunction

    function automatic logic [2:0] delay_field(input logic [5:0] s);
        return s[FRRS_DELAY_MSB:FRRS_DELAY_LSB];
    endfunction

    // true while another attempt is still owed for this code
    function automatic logic attempts_left(
        input logic [2:0] code,
        input logic [2:0] used
    );
        return (code == FRRS_RETRY_CONT) || (used < code);
    endfunction

    // ------------------------------------------------------------
    // start conditions
    // ------------------------------------------------------------
    assign stop_cont = !cmd_on || !bias_ok || other_fault;

    // a fresh fault from idle, unless the code forbids any restart
    assign first_fault = (state_reg == FRRS_IDLE) && fault_shutdown &&
        (retry_field(fault_setting) != FRRS_RETRY_NONE);

    // an attempt that failed while more attempts are still owed
    assign again_fault = (state_reg == FRRS_ATTEMPT) && fault_shutdown &&
        !stop_cont && attempts_left(retry_code_reg, count_reg);

    assign tmr_start = first_fault || again_fault;

    // delay ran out and nothing told a continuous run to stop
    assign launch = (state_reg == FRRS_WAIT) && tmr_done &&
        !(retry_code_reg == FRRS_RETRY_CONT && stop_cont);

    // idle has not latched the code yet, so it is taken live there
    assign tmr_code = (state_reg == FRRS_IDLE) ?
        delay_field(fault_setting) : delay_code_reg;

    frrs_delay_timer #(
        .UNIT_W(UNIT_W)
    ) u_timer (
        .clk(clk),
        .rst_n(rst_n),
        .start(tmr_start),
        .code(tmr_code),
        .unit_cycles(UNIT_CYCLES),
        .busy(),
        .done(tmr_done)
    );

    // ------------------------------------------------------------
    // sequencer state
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= FRRS_IDLE;
        end else if (fault_clear) begin
            state_reg <= FRRS_IDLE;
        end else begin
            case (state_reg)
                FRRS_IDLE: begin
                    if (first_fault) begin
                        state_reg <= FRRS_WAIT;
                    end else if (fault_shutdown) begin
                        state_reg <= FRRS_LOCKOUT;
                    end
                end
                FRRS_WAIT: begin
                    if (retry_code_reg == FRRS_RETRY_CONT && stop_cont) begin
                        state_reg <= FRRS_LOCKOUT;
                    end else if (tmr_done) begin
                        state_reg <= FRRS_ATTEMPT;
                    end
                end
                FRRS_ATTEMPT: begin
                    if (again_fault) begin
                        state_reg <= FRRS_WAIT;
                    end else if (fault_shutdown) begin
                        state_reg <= FRRS_LOCKOUT;
                    end else if (restart_ok) begin
                        state_reg <= FRRS_IDLE;
                    end
                end
                FRRS_LOCKOUT: begin
                    state_reg <= FRRS_LOCKOUT;
                end
                default: begin
                    state_reg <= FRRS_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // latched setting
    // ------------------------------------------------------------
    // a fresh fault latches the setting so mid-sequence writes
    // cannot change the number of attempts already promised
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            retry_code_reg <= 3'h0;
            delay_code_reg <= 3'h0;
        end else if (!fault_clear && state_reg == FRRS_IDLE &&
            fault_shutdown) begin
            retry_code_reg <= retry_field(fault_setting);
            delay_code_reg <= delay_field(fault_setting);
        end
    end

    // ------------------------------------------------------------
    // attempt counter
    // ------------------------------------------------------------
    // continuous mode never counts, so the 3-bit counter cannot wrap
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_reg <= 3'h0;
        end else if (fault_clear) begin
            count_reg <= 3'h0;
        end else if (state_reg == FRRS_IDLE && fault_shutdown) begin
            count_reg <= 3'h0;
        end else if (state_reg == FRRS_ATTEMPT && !fault_shutdown &&
            restart_ok) begin
            count_reg <= 3'h0;
        end else if (launch && retry_code_reg != FRRS_RETRY_CONT) begin
            count_reg <= count_reg + 3'h1;
        end
    end

    // ------------------------------------------------------------
    // output stage enable
    // ------------------------------------------------------------
    // clear re-enables at once; idle then follows command and bias
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            output_enable <= FRRS_EN_RESET;
        end else if (fault_clear) begin
            output_enable <= 1'b1;
        end else begin
            case (state_reg)
                FRRS_IDLE: begin
                    output_enable <= cmd_on && bias_ok && !fault_shutdown;
                end
                FRRS_WAIT: begin
                    output_enable <= launch;
                end
                FRRS_ATTEMPT: begin
                    output_enable <= output_enable && !fault_shutdown;
                end
                default: begin
                    output_enable <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // attempt start strobe
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            restart_pulse <= 1'b0;
        end else begin
            restart_pulse <= launch && !fault_clear;
        end
    end

    // ------------------------------------------------------------
    // status
    // ------------------------------------------------------------
    // taken from the state, not the timer, so there is no gap
    // between the end of a delay and the attempt that follows
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            locked_out <= 1'b0;
            retrying <= 1'b0;
        end else begin
            locked_out <= (state_reg == FRRS_LOCKOUT);
            retrying <= (state_reg == FRRS_WAIT) ||
                (state_reg == FRRS_ATTEMPT);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            attempts_used <= 3'h0;
        end else begin
            attempts_used <= count_reg;
        end
    end

endmodule

// >>> tb/frrs_sequencer_props.sv
// Purpose: port assertions for the retry sequencer
// Assumes: setting held steady through a sequence
// Notes: gap_reg times fault sample to attempt start
`timescale 1ns/100ps
module frrs_sequencer_props
    import frrs_pkg::*;
#(
    parameter int UNIT_W = 24,
    parameter logic [UNIT_W-1:0] UNIT_CYCLES = 24'h19
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [5:0] fault_setting,
    input wire logic fault_shutdown,
    input wire logic restart_ok,
    input wire logic fault_clear,
    input wire logic cmd_on,
    input wire logic bias_ok,
    input wire logic other_fault,
    input wire logic output_enable,
    input wire logic restart_pulse,
    input wire logic locked_out,
    input wire logic retrying,
    input wire logic [2:0] attempts_used
);
    logic [15:0] gap_reg;
    wire logic [2:0] rc = fault_setting[5:3];
    wire logic stop = !cmd_on || !bias_ok || other_fault;
    always_ff @(posedge clk) begin
        if (!rst_n || fault_shutdown) begin
            gap_reg <= 16'h0;
        end else begin
            gap_reg <= gap_reg + 16'h1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_gap;
        restart_pulse |-> gap_reg ==
            16'(UNIT_CYCLES) * (16'h1 << fault_setting[2:0]) + 16'h1;
    endproperty
    property p_pulse;
        restart_pulse |-> output_enable && retrying ##1 !restart_pulse;
    endproperty
    property p_none;
        fault_shutdown && rc == 3'h0 && !retrying && !locked_out
            && !fault_clear |-> ##[1:3] locked_out;
    endproperty
    property p_hold;
        locked_out && !fault_clear && !$past(fault_clear)
            |=> !output_enable && !restart_pulse;
    endproperty
    property p_lim;
        retrying && rc != 3'h7 |-> attempts_used <= rc;
    endproperty
    property p_unlim;
        retrying && rc == 3'h7 && !stop && !$past(stop) |=> !locked_out;
    endproperty
    property p_stop;
        retrying && rc == 3'h7 && stop && !fault_clear |-> ##[1:3] locked_out;
    endproperty
    property p_clear;
        fault_clear |-> ##2 !locked_out && !retrying && attempts_used == 3'h0;
    endproperty
    a_gap: assert property (p_gap) else $error("start off time");
    a_pulse: assert property (p_pulse) else $error("bad start");
    a_none: assert property (p_none) else $error("code zero retried");
    a_hold: assert property (p_hold) else $error("lockout left");
    a_lim: assert property (p_lim) else $error("too many");
    a_unlim: assert property (p_unlim) else $error("endless stopped");
    a_stop: assert property (p_stop) else $error("endless kept on");
    a_clear: assert property (p_clear) else $error("clear failed");
    c_start: cover property (restart_pulse);
    c_stop: cover property (locked_out && rc == 3'h7);
    c_clear: cover property (fault_clear && locked_out);
endmodule

// >>> tb/frrs_stage_model.sv
// Purpose: fault detector and output stage stand-in
// Assumes: trip and heal come from the bench
// Notes: without heal every attempt faults one cycle after start
`timescale 1ns/100ps
module frrs_stage_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic output_enable,
    input wire logic restart_pulse,
    input wire logic trip,
    input wire logic heal,
    output logic fault_shutdown,
    output logic restart_ok
);
    always_ff @(posedge clk) begin
        fault_shutdown <= rst_n && (trip || (restart_pulse && !heal));
        restart_ok <= rst_n && heal && output_enable;
    end
endmodule

// >>> tb/test_fault_restart_retry_sequencer.sv
// Purpose: self-checking bench for the retry sequencer
// Assumes: unit shortened to 2 cycles
// Notes: rows hold {attempts, setting}
`timescale 1ns/100ps
module test_fault_restart_retry_sequencer;
    import frrs_pkg::*;
    logic clk, rst_n, fault_clear, cmd_on, bias_ok, other_fault, trip, heal;
    logic fault_shutdown, restart_ok, output_enable, restart_pulse;
    logic locked_out, retrying;
    logic [5:0] fault_setting;
    logic [2:0] attempts_used;
    int n_errors = 0, n_compared = 0, cyc = 0, np, gap;
    logic [8:0] rows [7] = '{9'h000, 9'h049, 9'h090, 9'h0da, 9'h120,
        9'h16b, 9'h1b7};
    frrs_sequencer #(
        .UNIT_CYCLES(24'h2)
    ) dut_u (
        .clk(clk),
        .rst_n(rst_n),
        .fault_setting(fault_setting),
        .fault_shutdown(fault_shutdown),
        .restart_ok(restart_ok),
        .fault_clear(fault_clear),
        .cmd_on(cmd_on),
        .bias_ok(bias_ok),
        .other_fault(other_fault),
        .output_enable(output_enable),
        .restart_pulse(restart_pulse),
        .locked_out(locked_out),
        .retrying(retrying),
        .attempts_used(attempts_used)
    );
    frrs_stage_model model_u (
        .clk(clk),
        .rst_n(rst_n),
        .output_enable(output_enable),
        .restart_pulse(restart_pulse),
        .trip(trip),
        .heal(heal),
        .fault_shutdown(fault_shutdown),
        .restart_ok(restart_ok)
    );
    initial begin
        clk = 0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            conclude();
        end
    end
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task conclude;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task go(input logic [5:0] s);
        @(posedge clk);
        fault_setting <= s;
        trip <= 1;
        @(posedge clk);
        trip <= 0;
    endtask
    task run(input int lim);
        int last;
        np = 0;
        last = 0;
        for (int t = 0; t < lim && locked_out !== 1'b1; t++) begin
            @(posedge clk);
            #1;
            if (restart_pulse === 1'b1) begin
                np++;
                gap = t - last;
                last = t;
            end
        end
    endtask
    task clear;
        @(posedge clk);
        fault_clear <= 1;
        @(posedge clk);
        fault_clear <= 0;
        repeat (3) @(posedge clk);
    endtask
    initial begin
        {rst_n, fault_clear, other_fault, trip, heal} = 0;
        {cmd_on, bias_ok, fault_setting} = 8'hc0;
        repeat (4) @(posedge clk);
        #1 chk("rst", 0, {output_enable, restart_pulse, locked_out});
        @(posedge clk) rst_n <= 1;
        foreach (rows[i]) begin
            go(rows[i][5:0]);
            run(3000);
            chk("attempts", rows[i][8:6], np);
            chk("off", 1, {output_enable, locked_out});
            chk("used", rows[i][8:6], attempts_used);
            // delay plus two cycles of sequencer plus one of model reply
            if (np > 1) chk("gap", 2 * (1 << rows[i][2:0]) + 3, gap);
            clear();
            #1 chk("clr", 0, {locked_out, retrying, attempts_used});
        end
        for (int k = 0; k < 3; k++) begin
            go(6'h38);
            run(60);
            chk("endless", 1, np > 6);
            @(posedge clk);
            {cmd_on, bias_ok, other_fault} <= {k != 0, k != 1, k == 2};
            run(5);
            chk("stop", 1, locked_out);
            @(posedge clk);
            {cmd_on, bias_ok, other_fault} <= 3'h6;
            clear();
        end
        heal <= 1;
        go(6'h1a);
        run(40);
        chk("heal", 3, {np == 1, output_enable});
        conclude();
    end
endmodule
bind frrs_sequencer frrs_sequencer_props #(
    .UNIT_W(UNIT_W),
    .UNIT_CYCLES(UNIT_CYCLES)
) props_u (
    .clk(clk),
    .rst_n(rst_n),
    .fault_setting(fault_setting),
    .fault_shutdown(fault_shutdown),
    .restart_ok(restart_ok),
    .fault_clear(fault_clear),
    .cmd_on(cmd_on),
    .bias_ok(bias_ok),
    .other_fault(other_fault),
    .output_enable(output_enable),
    .restart_pulse(restart_pulse),
    .locked_out(locked_out),
    .retrying(retrying),
    .attempts_used(attempts_used)
);
